//--- design/fal_fifo_regs.vh
// Constants of the almost-level FIFO: geometry, flag thresholds,
// register offsets, field positions and reset values.
// Assumes inclusion by bare name from files in design/.
`ifndef FAL_FIFO_REGS_VH
`define FAL_FIFO_REGS_VH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define FAL_DATA_W 18
`define FAL_ADDR_W 10
`define FAL_CNT_W 11
`define FAL_OFS_W 9
`define FAL_DEPTH 11'h400

// ----------------------------------------------------------------
// Flag thresholds
// ----------------------------------------------------------------
`define FAL_HALF_LEVEL 11'h201
`define FAL_ALMOST_TOP 11'h401
`define FAL_DEFAULT_OFS 11'h100

// ----------------------------------------------------------------
// Register word indexes on the Wishbone slave, decoded from byte address bits 5..2
// ----------------------------------------------------------------
`define FAL_REG_STATUS 4'h0
`define FAL_REG_IRQ_STAT 4'h1
`define FAL_REG_IRQ_MASK 4'h2
`define FAL_REG_OFFSET 4'h3
`define FAL_WB_ADDR_W 6

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define FAL_ST_ALMOST 0
`define FAL_ST_HALF 1
`define FAL_ST_SPACE 2
`define FAL_ST_AVAIL 3
`define FAL_ST_CNT_LSB 16
`define FAL_EV_ALMOST 0
`define FAL_EV_HALF 1
`define FAL_EV_FULL 2
`define FAL_EV_REFUSED 3
`define FAL_EV_W 4
`define FAL_OFS_ACT_LSB 16

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FAL_IRQ_MASK_RST 4'h0
`define FAL_IRQ_STAT_RST 4'h0

`endif

//--- design/fal_word_store.v
// Word store of the almost-level FIFO: 1024 words of 18 bits.
// Assumes one clock; write port is clocked, read port is combinational.
`timescale 1ns/100ps
`include "fal_fifo_regs.vh"

module fal_word_store
(
   // Clock
   input wire mclk,
   // Write port
   input wire wr_en,
   input wire [`FAL_ADDR_W-1:0] wr_addr,
   input wire [`FAL_DATA_W-1:0] wr_data,
   // Read port
   input wire [`FAL_ADDR_W-1:0] rd_addr,
   output wire [`FAL_DATA_W-1:0] rd_data
);

   reg [`FAL_DATA_W-1:0] mem [0:1023];

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // Words are stored exactly as presented, no inversion
   always @(posedge mclk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

   // Combinational read keeps fall-through of the first word simple
   assign rd_data = mem[rd_addr];

endmodule

//--- design/fal_fifo_top.v
// Almost-level FIFO: 1024 x 18 buffer with programmable almost flag,
// half-level, space and word-available flags, and a Wishbone slave.
// Assumes pins synchronous to mclk; side clocks are sampled strobes.
`timescale 1ns/100ps
`include "fal_fifo_regs.vh"

// Behaviour
// - Store 1024 words of 18 bits, in order
// - Read data equals written data, uninverted
// - Each side paced by its own clock
// - Almost flag high at count <= X+1 or >= 1025-X
// - Almost flag low between X+2 and 1024-X
// - Offset load falling edge captures data bits 8..0
// - Reset release with load low uses captured offset
// - Load held high through reset uses 256
// - Every reset redefines the thresholds
// - Half flag high at 513 or more words
// - Space flag high unless full; reset loads it low
// - Word flag high unless empty, read-clock timed
// - Unload needs both gates, enable, word flag
module fal_fifo_top
(
   // Clock and reset
   input wire mclk,
   input wire rstn,
   // Write side
   input wire write_side_clock,
   input wire write_en,
   input wire [`FAL_DATA_W-1:0] write_data_in,
   // Offset programming
   input wire offset_load_n,
   // Read side
   input wire read_side_clock,
   input wire read_gate_a,
   input wire read_gate_b,
   input wire out_enable,
   output wire [`FAL_DATA_W-1:0] read_data_out,
   output wire read_data_oe,
   // Flags
   output wire almost_boundary_flag,
   output wire half_level_flag,
   output wire space_avail_flag,
   output wire word_avail_flag,
   // Wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [`FAL_WB_ADDR_W-1:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output wire [31:0] wb_dat_o,
   output wire wb_ack_o,
   // Interrupt
   output wire irq
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   reg wclk_prev_ff;
   reg rclk_prev_ff;
   reg load_prev_ff;
   reg [`FAL_ADDR_W-1:0] wr_ptr_ff;
   reg [`FAL_ADDR_W-1:0] rd_ptr_ff;
   reg [`FAL_CNT_W-1:0] mem_cnt_ff;
   reg out_valid_ff;
   reg [`FAL_DATA_W-1:0] out_data_ff;
   reg [`FAL_OFS_W-1:0] offset_ff;
   reg [`FAL_CNT_W-1:0] act_ofs_ff;
   reg almost_ff;
   reg half_ff;
   reg space_ff;
   reg [`FAL_EV_W-1:0] irq_stat_ff;
   reg [`FAL_EV_W-1:0] irq_mask_ff;
   reg ack_ff;
   reg [31:0] rdata_ff;
   wire wr_edge;
   wire rd_edge;
   wire load_fall;
   wire do_write;
   wire refused;
   wire do_pop;
   wire out_load;
   wire out_drop;
   wire mem_take;
   wire mem_empty;
   wire [`FAL_DATA_W-1:0] mem_rd_data;
   wire [`FAL_CNT_W-1:0] total_cnt;
   reg [`FAL_CNT_W-1:0] nxt_mem_cnt;
   reg nxt_out_valid;
   wire [`FAL_CNT_W-1:0] nxt_total;
   wire [`FAL_CNT_W-1:0] low_edge;
   wire [`FAL_CNT_W-1:0] high_edge;
   wire nxt_almost;
   wire nxt_half;
   wire nxt_space;
   wire [`FAL_EV_W-1:0] events;
   wire wb_req;
   wire wb_wr;
   wire [3:0] reg_idx;
   reg [31:0] nxt_rdata;

   // ----------------------------------------------------------------
   // Side strobes
   // ----------------------------------------------------------------
   // Each side advances only on the rising edge of its own pin clock
   assign wr_edge = write_side_clock & ~wclk_prev_ff;
   assign rd_edge = read_side_clock & ~rclk_prev_ff;
   assign load_fall = ~offset_load_n & load_prev_ff;

   // Edge history runs through reset, so a load edge in reset is seen
   always @(posedge mclk)
   begin
      wclk_prev_ff <= write_side_clock;
      rclk_prev_ff <= read_side_clock;
      load_prev_ff <= offset_load_n;
   end

   // ----------------------------------------------------------------
   // Write and read decisions
   // ----------------------------------------------------------------
   // Writes into a full buffer are dropped and reported as an event
   assign do_write = wr_edge & write_en & space_ff;
   assign refused = wr_edge & write_en & ~space_ff;
   // Unload of a held word needs both gates, drive enable, word flag
   assign do_pop = rd_edge & read_gate_a & read_gate_b & out_enable
      & out_valid_ff;
   assign mem_empty = (mem_cnt_ff == {`FAL_CNT_W{1'b0}});
   // First word falls through to the output without the read gates
   assign out_load = rd_edge & (do_pop | ~out_valid_ff) & ~mem_empty;
   assign out_drop = do_pop & mem_empty;
   assign mem_take = out_load;

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   fal_word_store u_store
   (
      .mclk(mclk),
      .wr_en(do_write),
      .wr_addr(wr_ptr_ff),
      .wr_data(write_data_in),
      .rd_addr(rd_ptr_ff),
      .rd_data(mem_rd_data)
   );

   // ----------------------------------------------------------------
   // Pointers, word count and output stage
   // ----------------------------------------------------------------
   // Count covers the store plus the word waiting at the outputs
   assign total_cnt = mem_cnt_ff + {{(`FAL_CNT_W-1){1'b0}}, out_valid_ff};

   always @*
   begin
      nxt_mem_cnt = mem_cnt_ff;
      if (do_write & ~mem_take)
      begin
         nxt_mem_cnt = mem_cnt_ff + 11'h001;
      end
      else if (mem_take & ~do_write)
      begin
         nxt_mem_cnt = mem_cnt_ff - 11'h001;
      end
      nxt_out_valid = out_valid_ff;
      if (out_load)
      begin
         nxt_out_valid = 1'b1;
      end
      else if (out_drop)
      begin
         nxt_out_valid = 1'b0;
      end
   end

   assign nxt_total = nxt_mem_cnt + {{(`FAL_CNT_W-1){1'b0}}, nxt_out_valid};

   // Pointers wrap at 1024, so order of words is kept
   always @(posedge mclk)
   begin
      if (!rstn)
      begin
         wr_ptr_ff <= {`FAL_ADDR_W{1'b0}};
         rd_ptr_ff <= {`FAL_ADDR_W{1'b0}};
         mem_cnt_ff <= {`FAL_CNT_W{1'b0}};
         out_valid_ff <= 1'b0;
         out_data_ff <= {`FAL_DATA_W{1'b0}};
      end
      else
      begin
         if (do_write)
         begin
            wr_ptr_ff <= wr_ptr_ff + 10'h001;
         end
         if (mem_take)
         begin
            rd_ptr_ff <= rd_ptr_ff + 10'h001;
            out_data_ff <= mem_rd_data;
         end
         mem_cnt_ff <= nxt_mem_cnt;
         out_valid_ff <= nxt_out_valid;
      end
   end

   // ----------------------------------------------------------------
   // Offset capture and threshold selection
   // ----------------------------------------------------------------
   // Offset is data, kept out of reset so a loaded value survives it
   always @(posedge mclk)
   begin
      if (load_fall)
      begin
         offset_ff <= write_data_in[`FAL_OFS_W-1:0];
      end
   end

   // In reset the threshold follows the load pin; release freezes it
   always @(posedge mclk)
   begin
      if (!rstn)
      begin
         if (offset_load_n)
         begin
            act_ofs_ff <= `FAL_DEFAULT_OFS;
         end
         else if (load_fall)
         begin
            act_ofs_ff <= {2'b00, write_data_in[`FAL_OFS_W-1:0]};
         end
         else
         begin
            act_ofs_ff <= {2'b00, offset_ff};
         end
      end
   end

   // ----------------------------------------------------------------
   // Flags
   // ----------------------------------------------------------------
   assign low_edge = act_ofs_ff + 11'h001;
   assign high_edge = `FAL_ALMOST_TOP - act_ofs_ff;
   // Both comparisons at once; the gap between them is the low zone
   assign nxt_almost = (nxt_total <= low_edge) | (nxt_total >= high_edge);
   assign nxt_half = (nxt_total >= `FAL_HALF_LEVEL);
   assign nxt_space = (nxt_total != `FAL_DEPTH);

   // Flags registered from the next count, in step with every access
   always @(posedge mclk)
   begin
      if (!rstn)
      begin
         almost_ff <= 1'b1;
         half_ff <= 1'b0;
         space_ff <= 1'b0;
      end
      else
      begin
         almost_ff <= nxt_almost;
         half_ff <= nxt_half;
         space_ff <= nxt_space;
      end
   end

   assign almost_boundary_flag = almost_ff;
   assign half_level_flag = half_ff;
   assign space_avail_flag = space_ff;
   assign word_avail_flag = out_valid_ff;
   assign read_data_out = out_data_ff;
   assign read_data_oe = out_enable;

   // ----------------------------------------------------------------
   // Interrupt status
   // ----------------------------------------------------------------
   assign events[`FAL_EV_ALMOST] = nxt_almost & ~almost_ff & rstn;
   assign events[`FAL_EV_HALF] = nxt_half & ~half_ff;
   assign events[`FAL_EV_FULL] = ~nxt_space & space_ff;
   assign events[`FAL_EV_REFUSED] = refused;
   assign wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign wb_wr = wb_req & wb_we_i;
   assign reg_idx = wb_adr_i[5:2];

   // A new event beats a write-one-to-clear in the same cycle
   always @(posedge mclk)
   begin
      if (!rstn)
      begin
         irq_stat_ff <= `FAL_IRQ_STAT_RST;
         irq_mask_ff <= `FAL_IRQ_MASK_RST;
      end
      else
      begin
         if (wb_wr && reg_idx == `FAL_REG_IRQ_STAT && wb_sel_i[0])
         begin
            irq_stat_ff <= (irq_stat_ff & ~wb_dat_i[`FAL_EV_W-1:0]) | events;
         end
         else
         begin
            irq_stat_ff <= irq_stat_ff | events;
         end
         if (wb_wr && reg_idx == `FAL_REG_IRQ_MASK && wb_sel_i[0])
         begin
            irq_mask_ff <= wb_dat_i[`FAL_EV_W-1:0];
         end
      end
   end

   assign irq = |(irq_stat_ff & irq_mask_ff);

   // ----------------------------------------------------------------
   // Wishbone read mux
   // ----------------------------------------------------------------
   // Unmapped offsets read as zero and are still acknowledged
   always @*
   begin
      nxt_rdata = 32'h00000000;
      case (reg_idx)
         `FAL_REG_STATUS:
         begin
            nxt_rdata[`FAL_ST_ALMOST] = almost_ff;
            nxt_rdata[`FAL_ST_HALF] = half_ff;
            nxt_rdata[`FAL_ST_SPACE] = space_ff;
            nxt_rdata[`FAL_ST_AVAIL] = out_valid_ff;
            nxt_rdata[`FAL_ST_CNT_LSB+`FAL_CNT_W-1:`FAL_ST_CNT_LSB] = total_cnt;
         end
         `FAL_REG_IRQ_STAT:
         begin
            nxt_rdata[`FAL_EV_W-1:0] = irq_stat_ff;
         end
         `FAL_REG_IRQ_MASK:
         begin
            nxt_rdata[`FAL_EV_W-1:0] = irq_mask_ff;
         end
         `FAL_REG_OFFSET:
         begin
            nxt_rdata[`FAL_OFS_W-1:0] = offset_ff;
            nxt_rdata[`FAL_OFS_ACT_LSB+`FAL_CNT_W-1:`FAL_OFS_ACT_LSB] = act_ofs_ff;
         end
         default:
         begin
            nxt_rdata = 32'h00000000;
         end
      endcase
   end

   // One wait state: ack one cycle after the request, dropped after
   always @(posedge mclk)
   begin
      if (!rstn)
      begin
         ack_ff <= 1'b0;
         rdata_ff <= 32'h00000000;
      end
      else
      begin
         ack_ff <= wb_req;
         if (wb_req)
         begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   assign wb_ack_o = ack_ff;
   assign wb_dat_o = rdata_ff;

endmodule

//--- sim/fal_fifo_props.sv
// Assertions on the almost-level FIFO pins, bound to its top module.
// Assumes one clock, mclk, and a synchronous active-low rstn.
`timescale 1ns/100ps
`include "fal_fifo_regs.vh"

module fal_fifo_props
(
   // Clock and reset
   input wire mclk,
   input wire rstn,
   // Side strobes and gates
   input wire write_side_clock,
   input wire write_en,
   input wire read_side_clock,
   input wire read_gate_a,
   input wire read_gate_b,
   input wire out_enable,
   // Outputs
   input wire [`FAL_DATA_W-1:0] read_data_out,
   input wire read_data_oe,
   input wire almost_boundary_flag,
   input wire half_level_flag,
   input wire space_avail_flag,
   input wire word_avail_flag
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);

   // Past rstn keeps the reset values out of the first edge after release
   a_oe_follow: assert property (read_data_oe == out_enable)
      else $error("output enable not passed through");
   a_full_flags: assert property ($past(rstn) && !space_avail_flag |->
      half_level_flag && almost_boundary_flag) else $error("full without half and almost");
   a_full_hold: assert property ($past(rstn) && !space_avail_flag &&
      !$rose(read_side_clock) |=> !space_avail_flag) else $error("full left without a read");
   a_space_drop: assert property ($fell(space_avail_flag) |-> $past(write_en) &&
      $past(write_side_clock) && !$past(write_side_clock, 2)) else $error("full without write");
   a_half_rise: assert property ($rose(half_level_flag) |-> $past(write_en) &&
      $past(write_side_clock) && !$past(write_side_clock, 2)) else $error("half without write");
   a_avail_step: assert property ($rose(word_avail_flag) |->
      $past(read_side_clock) && !$past(read_side_clock, 2)) else $error("word flag off step");
   a_avail_drop: assert property ($fell(word_avail_flag) |-> $past(read_side_clock) &&
      $past(read_gate_a && read_gate_b && out_enable)) else $error("word flag fell ungated");
   a_head_hold: assert property (word_avail_flag && !($rose(read_side_clock) &&
      read_gate_a && read_gate_b && out_enable) |=> $stable(read_data_out) && word_avail_flag)
      else $error("head word moved without an unload");

   // Main scenarios reached
   c_full: cover property ($fell(space_avail_flag));
   c_half: cover property ($rose(half_level_flag));
   c_unload: cover property ($fell(word_avail_flag));
endmodule

bind fal_fifo_top fal_fifo_props u_fal_fifo_props (.*);

//--- sim/fal_far.sv
// Far-side producer and consumer of the almost-level FIFO.
// Assumes its tasks are called one at a time from the bench.
`timescale 1ns/100ps
`include "fal_fifo_regs.vh"

module fal_far
(
   // Clock
   input wire mclk,
   // Producer pins
   output logic write_side_clock,
   output logic write_en,
   output logic [`FAL_DATA_W-1:0] write_data_in,
   output logic offset_load_n,
   // Consumer pins
   output logic read_side_clock,
   output logic read_gate_a,
   output logic read_gate_b,
   output logic out_enable,
   input wire [`FAL_DATA_W-1:0] read_data_out,
   input wire word_avail_flag,
   // Unloaded word, for the bench
   output logic got,
   output logic [`FAL_DATA_W-1:0] got_word
);
   // Quiet pins; load high selects the default offset
   initial
   begin
      {write_side_clock, write_en, read_side_clock, got} = 4'h0;
      {read_gate_a, read_gate_b, out_enable} = 3'h0;
      offset_load_n = 1'b1;
      write_data_in = 18'h0;
      got_word = 18'h0;
   end

   // One write strobe; the bus is scrambled after it so late samples show
   task automatic put(input logic [17:0] d);
   begin
      @(posedge mclk);
      write_side_clock <= 1'b1;
      write_en <= 1'b1;
      write_data_in <= d;
      @(posedge mclk);
      write_side_clock <= 1'b0;
      write_en <= 1'b0;
      write_data_in <= ~d;
   end
   endtask

   // Offset on the low data bits, then load falls and stays low
   task automatic load(input logic [8:0] x);
   begin
      @(posedge mclk);
      write_data_in <= {9'h000, x};
      @(posedge mclk);
      offset_load_n <= 1'b0;
      @(posedge mclk);
      write_data_in <= ~{9'h000, x};
   end
   endtask

   // Load returns high so the next reset takes the default
   task automatic unload;
   begin
      @(posedge mclk);
      offset_load_n <= 1'b1;
   end
   endtask

   // Read step with gate vector {a, b, enable}; a first step loads the head
   task automatic take(input logic [2:0] g);
   begin
      if (word_avail_flag !== 1'b1)
      begin
         @(posedge mclk);
         read_side_clock <= 1'b1;
         @(posedge mclk);
         read_side_clock <= 1'b0;
      end
      @(posedge mclk);
      read_side_clock <= 1'b1;
      {read_gate_a, read_gate_b, out_enable} <= g;
      got <= &g;
      got_word <= read_data_out;
      @(posedge mclk);
      read_side_clock <= 1'b0;
      {read_gate_a, read_gate_b, out_enable} <= 3'h0;
      got <= 1'b0;
   end
   endtask
endmodule

//--- sim/tb_top.sv
// Bench of the almost-level FIFO: offsets, flags, word order, registers.
// Assumes the far-side model drives all producer and consumer pins.
`timescale 1ns/100ps
`include "fal_fifo_regs.vh"

module tb_top;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic wb_cyc_i = 1'b0;
   logic wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0;
   logic [5:0] wb_adr_i = 6'h00;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 32'h0;
   wire [31:0] wb_dat_o;
   wire wb_ack_o, irq, almost_boundary_flag, half_level_flag, space_avail_flag;
   wire write_side_clock, write_en, offset_load_n, read_side_clock, read_data_oe;
   wire read_gate_a, read_gate_b, out_enable, word_avail_flag, got;
   wire [17:0] write_data_in, read_data_out, got_word;
   logic [31:0] lfsr = 32'h009F;
   logic [31:0] rd;
   logic [17:0] exp_q[$];
   int bad_count = 0;
   int tests_run = 0;
   int cnt = 0;
   logic seen = 1'b0;

   fal_fifo_top u_fal_fifo_top (.*);
   fal_far u_fal_far (.*);

   always #25 mclk = ~mclk;

   function automatic logic [31:0] nxt_rand(input logic [31:0] s);
      nxt_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic end_of_test;
   begin
      $display("Checks %0d, mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   end
   endtask

   task automatic cmp_val(input string n, input logic [31:0] e, input logic [31:0] s);
   begin
      tests_run++;
      if (s !== e)
      begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   end
   endtask

   // Classic single cycle; a missing ack ends the run
   task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
      int n;
   begin
      @(posedge mclk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1)
      begin
         cmp_val("ack", 32'h1, 32'h0);
         end_of_test;
      end
      else
      begin
         rd = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
      end
   end
   endtask

   // Flags against the count, read where they have settled
   task automatic chk_flags(input int x);
      logic [3:0] e;
   begin
      @(negedge mclk);
      e[0] = (cnt <= x + 1) || (cnt >= 1025 - x);
      e[1] = cnt >= 513;
      e[2] = cnt != 1024;
      e[3] = seen && cnt != 0;
      cmp_val("flags", {28'h0, e}, {28'h0, word_avail_flag, space_avail_flag,
         half_level_flag, almost_boundary_flag});
   end
   endtask

   task automatic pulse_reset;
   begin
      @(posedge mclk);
      rstn <= 1'b0;
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      cnt = 0;
      seen = 1'b0;
   end
   endtask

   // Oldest noted word against each unloaded word
   always @(posedge mclk)
      if (got === 1'b1)
         cmp_val("word", {14'h0, exp_q.pop_front()}, {14'h0, got_word});

   // Fill until refused, check registers and interrupt, drain with stalls
   task automatic run(input int x);
      logic [17:0] d;
   begin
      wb(1'b0, 6'h0C, 32'h0);
      cmp_val("active offset", 32'(x), {21'h0, rd[26:16]});
      chk_flags(x);
      repeat (1024)
      begin
         lfsr = nxt_rand(lfsr);
         d = lfsr[17:0];
         u_fal_far.put(d);
         exp_q.push_back(d);
         cnt++;
         chk_flags(x);
      end
      u_fal_far.put(18'h3FFFF);
      chk_flags(x);
      wb(1'b0, 6'h00, 32'h0);
      cmp_val("status", 32'h04000003, rd);
      wb(1'b0, 6'h04, 32'h0);
      cmp_val("irq status", 32'h0000000F, rd);
      wb(1'b1, 6'h08, 32'h8);
      cmp_val("irq raised", 32'h1, {31'h0, irq});
      wb(1'b1, 6'h04, 32'hF);
      cmp_val("irq cleared", 32'h0, {31'h0, irq});
      wb(1'b0, 6'h30, 32'h0);
      cmp_val("unmapped", 32'h0, rd);
      seen = 1'b1;
      repeat (1024)
      begin
         u_fal_far.take(3'b111 ^ (3'b001 << (cnt % 3)));
         u_fal_far.take(3'b111);
         cnt--;
         chk_flags(x);
      end
      cmp_val("words left", 32'h0, exp_q.size());
      $display("Fill and drain with offset %0d done", x);
   end
   endtask

   // Default offset, then a programmed one kept and then dropped
   initial
   begin
      repeat (3) @(posedge mclk);
      rstn <= 1'b1;
      run(256);
      u_fal_far.load(9'h005);
      pulse_reset;
      run(5);
      pulse_reset;
      wb(1'b0, 6'h0C, 32'h0);
      cmp_val("kept offset", 32'h00050005, rd);
      u_fal_far.unload;
      pulse_reset;
      wb(1'b0, 6'h0C, 32'h0);
      cmp_val("default offset", 32'h01000005, rd);
      $display("Offset retention done");
      end_of_test;
   end
endmodule
